// File: position_sequencer.sv
// multi-segment position sequencer with register port and interrupt
`timescale 1ns/1ps
`include "seq_params.svh"
module position_sequencer #(
  parameter int DIST_W = 32,
  parameter int SEGS   = 16
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // register port
  input  wire logic [5:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata_q,
  // host digital inputs
  input  wire logic              motion_enable_input,
  input  wire logic              segment_select_bit0,
  input  wire logic              segment_select_bit1,
  input  wire logic              segment_select_bit2,
  input  wire logic              segment_select_bit3,
  input  wire logic              append_trigger_input,
  input  wire logic              interrupt_trigger_input,
  // position loop
  input  wire logic              move_finished,
  output logic                   move_start_q,
  output logic      [DIST_W-1:0] move_distance_q,
  output logic                   move_abort_q,
  // status outputs
  output logic                   positioning_done_output_q,
  output logic                   seq_busy_q,
  output logic                   irq_q
);

  import seq_pkg::*;

  seq_state_t        state_q;
  logic [7:0]        mode_q;
  logic [4:0]        count_q;
  logic [4:0]        start_q;
  logic [DIST_W-1:0] single_q;
  logic [2:0]        irq_stat_q;
  logic [2:0]        irq_stat_d;
  logic [2:0]        irq_mask_q;
  logic [15:0]       done_cnt_q;
  logic [3:0]        idx_q;
  logic              en_prev_q;
  logic              hold_q;
  logic              pend_q;
  logic [DIST_W-1:0] pend_dist_q;
  logic              pass_evt_q;
  logic [DIST_W-1:0] tbl_rd_b;
  logic [31:0]       rd_mux;
  logic              en_rise;
  logic              tbl_hit;
  logic [3:0]        sel_idx;
  logic [3:0]        last_idx;
  logic              start_ok;
  logic              seg_end;

  assign en_rise  = motion_enable_input & ~en_prev_q;
  assign tbl_hit  = (reg_addr[5:4] == `TBL_SEL);
  assign sel_idx  = {segment_select_bit3, segment_select_bit2,
                     segment_select_bit1, segment_select_bit0};
  assign last_idx = 4'(count_q - 5'h01);
  assign start_ok = (start_q != 5'h00) && (start_q <= count_q);
  assign seg_end  = (state_q == st_run) && move_finished;

  // segment distance table
  seg_table #(
    .DW    (DIST_W),
    .DEPTH (SEGS),
    .AW    (4)
  ) u_table (
    .core_clk (core_clk),
    .wr_en    (reg_wr & tbl_hit),
    .wr_addr  (reg_addr[3:0]),
    .wr_data  (reg_wdata[DIST_W-1:0]),
    .a_addr   (reg_addr[3:0]),
    .a_data_q (),
    .b_addr   (idx_q),
    .b_data_q (tbl_rd_b)
  );

  // configuration registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q     <= `MODE_RST;
      count_q    <= `COUNT_RST;
      start_q    <= `START_RST;
      single_q   <= '0;
      irq_mask_q <= `MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_MODE: begin
          mode_q <= reg_wdata[7:0];
        end
        `REG_COUNT: begin
          if (reg_wdata[4:0] >= `COUNT_MIN &&
              reg_wdata[4:0] <= `COUNT_MAX &&
              reg_wdata[31:5] == '0) begin
            count_q <= reg_wdata[4:0];
          end
        end
        `REG_START: begin
          if (reg_wdata[4:0] <= `START_MAX && reg_wdata[31:5] == '0) begin
            start_q <= reg_wdata[4:0];
          end
        end
        `REG_SINGLE: begin
          single_q <= reg_wdata[DIST_W-1:0];
        end
        `REG_IRQ_MASK: begin
          irq_mask_q <= reg_wdata[2:0];
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // enable edge detect
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= motion_enable_input;
    end
  end

  // sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q                   <= st_idle;
      idx_q                     <= 4'h0;
      hold_q                    <= 1'b0;
      pend_q                    <= 1'b0;
      pend_dist_q               <= '0;
      move_start_q              <= 1'b0;
      move_abort_q              <= 1'b0;
      move_distance_q           <= '0;
      positioning_done_output_q <= 1'b0;
      pass_evt_q                <= 1'b0;
    end else begin
      move_start_q              <= 1'b0;
      move_abort_q              <= 1'b0;
      positioning_done_output_q <= 1'b0;
      pass_evt_q                <= 1'b0;
      if (!motion_enable_input) begin
        hold_q <= 1'b0;
      end
      case (state_q)
        st_idle: begin
          if (mode_q == mode_di_select && en_rise) begin
            idx_q   <= sel_idx;
            state_q <= st_fetch;
          end else if (mode_q == mode_seq_pass && motion_enable_input &&
                       !hold_q) begin
            if (idx_q > last_idx) begin
              idx_q <= 4'h0;
            end
            state_q <= st_fetch;
          end else if (mode_q == mode_axis && motion_enable_input &&
                       !hold_q) begin
            move_distance_q <= single_q;
            move_start_q    <= 1'b1;
            pend_q          <= 1'b0;
            state_q         <= st_run;
          end
        end
        st_fetch: begin
          state_q <= st_load;
        end
        st_load: begin
          move_distance_q <= tbl_rd_b;
          move_start_q    <= 1'b1;
          state_q         <= st_run;
        end
        st_run: begin
          if (mode_q != mode_di_select && !motion_enable_input) begin
            move_abort_q <= 1'b1;
            pend_q       <= 1'b0;
            state_q      <= st_idle;
          end else if (mode_q == mode_axis && interrupt_trigger_input) begin
            move_abort_q    <= 1'b1;
            move_distance_q <= single_q;
            move_start_q    <= 1'b1;
            pend_q          <= 1'b0;
          end else if (move_finished) begin
            positioning_done_output_q <= 1'b1;
            if (mode_q == mode_seq_pass) begin
              if (idx_q >= last_idx) begin
                if (start_ok) begin
                  idx_q   <= 4'(start_q - 5'h01);
                  state_q <= st_fetch;
                end else begin
                  idx_q      <= 4'h0;
                  hold_q     <= 1'b1;
                  pass_evt_q <= 1'b1;
                  state_q    <= st_idle;
                end
              end else begin
                idx_q   <= idx_q + 4'h1;
                state_q <= st_fetch;
              end
            end else if (mode_q == mode_axis) begin
              if (append_trigger_input) begin
                move_distance_q <= single_q;
                move_start_q    <= 1'b1;
                pend_q          <= 1'b0;
              end else if (pend_q) begin
                move_distance_q <= pend_dist_q;
                move_start_q    <= 1'b1;
                pend_q          <= 1'b0;
              end else begin
                hold_q  <= 1'b1;
                state_q <= st_idle;
              end
            end else begin
              state_q <= st_idle;
            end
          end else if (mode_q == mode_axis && append_trigger_input) begin
            pend_q      <= 1'b1;
            pend_dist_q <= single_q;
          end
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // busy flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_busy_q <= 1'b0;
    end else begin
      seq_busy_q <= (state_q != st_idle);
    end
  end

  // completed segment counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_cnt_q <= 16'h0000;
    end else if (reg_wr && reg_addr == `REG_DONE_CNT) begin
      done_cnt_q <= 16'h0000;
    end else if (seg_end && !(mode_q != mode_di_select &&
                 !motion_enable_input)) begin
      done_cnt_q <= done_cnt_q + 16'h0001;
    end
  end

  // sticky event bits, set wins over clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (reg_wr && reg_addr == `REG_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[2:0];
    end
    if (positioning_done_output_q) begin
      irq_stat_d[`IRQ_SEG_DONE] = 1'b1;
    end
    if (pass_evt_q) begin
      irq_stat_d[`IRQ_PASS_DONE] = 1'b1;
    end
    if (move_abort_q) begin
      irq_stat_d[`IRQ_ABORT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // read data
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `REG_MODE: begin
        rd_mux = {24'h00_0000, mode_q};
      end
      `REG_COUNT: begin
        rd_mux = {27'h0, count_q};
      end
      `REG_START: begin
        rd_mux = {27'h0, start_q};
      end
      `REG_SINGLE: begin
        rd_mux = 32'(single_q);
      end
      `REG_STATUS: begin
        rd_mux = {21'h0, pend_q, hold_q, state_q, idx_q, 1'b0,
                  motion_enable_input, seq_busy_q};
      end
      `REG_IRQ_STAT: begin
        rd_mux = {29'h0, irq_stat_q};
      end
      `REG_IRQ_MASK: begin
        rd_mux = {29'h0, irq_mask_q};
      end
      `REG_DIST: begin
        rd_mux = 32'(move_distance_q);
      end
      `REG_DONE_CNT: begin
        rd_mux = {16'h0000, done_cnt_q};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// File: seq_params.svh
// constants of the multi-segment position sequencer
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define REG_MODE      6'h00
`define REG_COUNT     6'h01
`define REG_START     6'h02
`define REG_SINGLE    6'h03
`define REG_STATUS    6'h04
`define REG_IRQ_STAT  6'h05
`define REG_IRQ_MASK  6'h06
`define REG_DIST      6'h07
`define REG_DONE_CNT  6'h08
`define TBL_SEL       2'h1

`define MODE_RST      8'h02
`define COUNT_RST     5'h01
`define COUNT_MIN     5'h01
`define COUNT_MAX     5'h10
`define START_RST     5'h00
`define START_MAX     5'h10
`define MASK_RST      3'h0

`define IRQ_SEG_DONE  0
`define IRQ_PASS_DONE 1
`define IRQ_ABORT     2

`endif

// File: seq_pkg.sv
// types of the multi-segment position sequencer
package seq_pkg;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_fetch = 2'b01,
    st_load  = 2'b10,
    st_run   = 2'b11
  } seq_state_t;

  typedef enum logic [7:0] {
    mode_di_select = 8'h02,
    mode_seq_pass  = 8'h03,
    mode_axis      = 8'h05
  } op_mode_t;

endpackage

// File: seg_table.sv
// segment distance table, one write port, two registered read ports
`timescale 1ns/1ps
module seg_table #(
  parameter int DW    = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic          core_clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port a
  input  wire logic [AW-1:0] a_addr,
  output logic      [DW-1:0] a_data_q,
  // read port b
  input  wire logic [AW-1:0] b_addr,
  output logic      [DW-1:0] b_data_q
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    a_data_q <= mem[a_addr];
    b_data_q <= mem[b_addr];
  end

endmodule

// File: position_sequencer_assertions.sv
// port checker for the position sequencer
`timescale 1ns/1ps
`include "seq_params.svh"
module seq_chk #(
  parameter int DIST_W = 32
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              arst_n,
  // register port
  input wire logic [5:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  // host inputs
  input wire logic              motion_enable_input,
  input wire logic              interrupt_trigger_input,
  // position loop and status
  input wire logic              move_finished,
  input wire logic              move_start_q,
  input wire logic [DIST_W-1:0] move_distance_q,
  input wire logic              move_abort_q,
  input wire logic              positioning_done_output_q,
  input wire logic              seq_busy_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0]        mode_q;
  logic [DIST_W-1:0] single_q;
  logic              run_q;
  // mirror of mode and single distance
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q   <= `MODE_RST;
      single_q <= '0;
    end else if (reg_wr && reg_addr == `REG_MODE) begin
      mode_q <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == `REG_SINGLE) begin
      single_q <= reg_wdata[DIST_W-1:0];
    end
  end
  // a distance is in the loop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) run_q <= 1'b0;
    else if (move_start_q) run_q <= 1'b1;
    else if (move_finished || move_abort_q) run_q <= 1'b0;
  end
  property p_done_fin;
    positioning_done_output_q |-> $past(move_finished);
  endproperty
  a_done_fin: assert property (p_done_fin)
    else $error("done without finished move");
  property p_done_pulse;
    positioning_done_output_q |=> !positioning_done_output_q;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_m2_start;
    mode_q == 8'h02 && $rose(motion_enable_input) && !seq_busy_q
      |-> ##3 move_start_q;
  endproperty
  a_m2_start: assert property (p_m2_start)
    else $error("enable edge gave no start");
  property p_m2_edge;
    mode_q == 8'h02 && move_start_q
      |-> $past(motion_enable_input, 3) && !$past(motion_enable_input, 4);
  endproperty
  a_m2_edge: assert property (p_m2_edge)
    else $error("start without enable edge");
  property p_seq_next;
    mode_q == 8'h03 && motion_enable_input && move_finished
      |-> ##[1:4] (move_start_q || !seq_busy_q);
  endproperty
  a_seq_next: assert property (p_seq_next)
    else $error("next segment late");
  property p_m5_abort;
    mode_q == 8'h05 && $fell(motion_enable_input) && run_q && !move_finished
      |=> move_abort_q;
  endproperty
  a_m5_abort: assert property (p_m5_abort)
    else $error("enable drop did not abort");
  property p_m5_dist;
    mode_q == 8'h05 && move_start_q |-> move_distance_q == single_q;
  endproperty
  a_m5_dist: assert property (p_m5_dist)
    else $error("distance not the single setting");
  property p_m5_int;
    mode_q == 8'h05 && interrupt_trigger_input && run_q && !move_finished
      |=> move_abort_q && move_start_q;
  endproperty
  a_m5_int: assert property (p_m5_int)
    else $error("interrupt did not restart");
endmodule
bind position_sequencer seq_chk #(.DIST_W(DIST_W)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .motion_enable_input(motion_enable_input),
  .interrupt_trigger_input(interrupt_trigger_input),
  .move_finished(move_finished), .move_start_q(move_start_q),
  .move_distance_q(move_distance_q), .move_abort_q(move_abort_q),
  .positioning_done_output_q(positioning_done_output_q),
  .seq_busy_q(seq_busy_q));

// File: pos_loop_model.sv
// position loop stand-in, finishes each move that is not aborted after a set delay
`timescale 1ns/1ps
module pos_loop_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // from the sequencer, and the move delay lat from the bench
  input  wire logic        move_start_q,
  input  wire logic [31:0] move_distance_q,
  input  wire logic        move_abort_q,
  input  wire logic [7:0]  lat,
  // move_finished back to the sequencer, travel to the bench
  output logic             move_finished,
  output logic [31:0]      travel
);
  logic [7:0]  cnt_q;
  logic [31:0] dist_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q         <= 8'h00;
      dist_q        <= 32'h0;
      travel        <= 32'h0;
      move_finished <= 1'b0;
    end else begin
      move_finished <= 1'b0;
      if (move_start_q) begin
        cnt_q  <= lat;
        dist_q <= move_distance_q;
      end else if (move_abort_q) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == 8'h01) begin
        cnt_q         <= 8'h00;
        move_finished <= 1'b1;
        travel        <= travel + dist_q;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// File: multi_segment_position_sequencer_test.sv
// self-checking bench for the position sequencer
`timescale 1ns/1ps
`include "seq_params.svh"
module multi_segment_position_sequencer_test;
  import seq_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0;
  logic        app = 1'b0, intr = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  lat = 8'h02;
  logic [31:0] reg_rdata_q, move_distance_q, travel, t0;
  logic        move_finished, move_start_q, move_abort_q, done, busy, irq;
  logic [3:0]  ix[3] = '{4'h0, 4'h9, 4'hf};
  logic [3:0]  m3[6] = '{4'h0, 4'h1, 4'h2, 4'h1, 4'h2, 4'h1};
  logic [31:0] st_q[$];
  int          failures = 0, checks = 0, cycles = 0, aborts = 0, dones = 0;
  position_sequencer dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .motion_enable_input(en),
    .segment_select_bit0(sel[0]), .segment_select_bit1(sel[1]),
    .segment_select_bit2(sel[2]), .segment_select_bit3(sel[3]),
    .append_trigger_input(app), .interrupt_trigger_input(intr),
    .move_finished(move_finished), .move_start_q(move_start_q),
    .move_distance_q(move_distance_q), .move_abort_q(move_abort_q),
    .positioning_done_output_q(done), .seq_busy_q(busy), .irq_q(irq));
  pos_loop_model u_loop (
    .core_clk(core_clk), .arst_n(arst_n), .move_start_q(move_start_q),
    .move_distance_q(move_distance_q), .move_abort_q(move_abort_q),
    .lat(lat), .move_finished(move_finished), .travel(travel));
  always #50 core_clk = ~core_clk;
  // record starts and aborts, cut a hang short
  always @(posedge core_clk) begin
    if (move_start_q) st_q.push_back(move_distance_q);
    if (move_abort_q) aborts++;
    if (done) dones++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rst(input int n);
    arst_n <= 1'b0;
    cyc(n);
    arst_n <= 1'b1;
    cyc(2);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata_q, e);
    cyc(1);
  endtask
  task automatic irq_is(input logic e);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
    cyc(1);
  endtask
  task automatic wait_q(input int n);
    while (st_q.size() < n) cyc(1);
  endtask
  task automatic idle();
    cyc(2);
    while (busy !== 1'b0) cyc(1);
  endtask
  task automatic trig(input logic a);
    if (a) app <= 1'b1;
    else intr <= 1'b1;
    cyc(1);
    app <= 1'b0;
    intr <= 1'b0;
  endtask
  initial begin
    rst(5);
    rd(`REG_COUNT, 32'h1);
    wr(`REG_COUNT, 32'h0);
    wr(`REG_COUNT, 32'h11);
    rd(`REG_COUNT, 32'h1);
    wr(`REG_COUNT, 32'h10);
    rd(`REG_COUNT, 32'h10);
    rd(6'h3f, 32'h0);
    for (int i = 0; i < 16; i++) wr(6'h10 + 6'(i), 32'h100 + 32'(i));
    // host-selected segments, next one selected mid-run, where an enable edge gives no start
    wr(`REG_MODE, {24'h0, mode_di_select});
    lat <= 8'd30;
    sel <= ix[0];
    for (int k = 0; k < 3; k++) begin
      en <= 1'b1;
      cyc(1);
      en <= 1'b0;
      wait_q(k + 1);
      chk(st_q[k], 32'h100 + 32'(ix[k]));
      sel <= ix[(k + 1) % 3];
      en <= 1'b1;
      cyc(1);
      en <= 1'b0;
      chk(move_distance_q, 32'h100 + 32'(ix[k]));
      idle();
      cyc(4);
      chk(32'(st_q.size()), 32'(k + 1));
    end
    chk(32'(dones), 32'h3);
    rd(`REG_DONE_CNT, 32'h3);
    // one pass, then stop and flag it
    rst(2);
    wr(`REG_COUNT, 32'h3);
    wr(`REG_MODE, {24'h0, mode_seq_pass});
    lat <= 8'd2;
    st_q.delete();
    en <= 1'b1;
    cyc(60);
    chk(32'(st_q.size()), 32'h3);
    for (int k = 0; k < 3; k++) chk(st_q[k], 32'h100 + 32'(k));
    chk({31'h0, irq}, 32'h0);
    rd(`REG_IRQ_STAT, 32'h3);
    wr(`REG_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    wr(`REG_IRQ_STAT, 32'h3);
    irq_is(1'b0);
    en <= 1'b0;
    // repeated passes from the start setting, then drop enable
    rst(2);
    wr(`REG_COUNT, 32'h3);
    wr(`REG_START, 32'h2);
    wr(`REG_MODE, {24'h0, mode_seq_pass});
    lat <= 8'd20;
    st_q.delete();
    aborts = 0;
    en <= 1'b1;
    wait_q(6);
    en <= 1'b0;
    cyc(4);
    for (int k = 0; k < 6; k++) chk(st_q[k], 32'h100 + 32'(m3[k]));
    chk(32'(aborts), 32'h1);
    // single distance: individual, appended, interrupted
    wr(`REG_MODE, {24'h0, mode_axis});
    wr(`REG_SINGLE, 32'd1000);
    lat <= 8'd30;
    st_q.delete();
    aborts = 0;
    t0 = travel;
    en <= 1'b1;
    wait_q(1);
    idle();
    cyc(5);
    chk(st_q[0], 32'd1000);
    chk(32'(st_q.size()), 32'h1);
    chk(travel - t0, 32'd1000);
    en <= 1'b0;
    cyc(2);
    en <= 1'b1;
    wait_q(2);
    wr(`REG_SINGLE, 32'd2000);
    trig(1'b1);
    wait_q(3);
    idle();
    chk(st_q[2], 32'd2000);
    chk(travel - t0, 32'd4000);
    en <= 1'b0;
    wr(`REG_SINGLE, 32'd500);
    en <= 1'b1;
    wait_q(4);
    wr(`REG_SINGLE, 32'd700);
    trig(1'b0);
    wait_q(5);
    idle();
    chk(32'(aborts), 32'h1);
    chk(st_q[4], 32'd700);
    chk(travel - t0, 32'd4700);
    en <= 1'b0;
    cyc(2);
    en <= 1'b1;
    wait_q(6);
    en <= 1'b0;
    cyc(4);
    chk(32'(aborts), 32'h2);
    rd(`REG_IRQ_STAT, 32'h5);
    rd(`REG_DIST, 32'd700);
    results();
  end
endmodule
